//--- src/sdisc_top.sv
// Purpose: output edge rate, polarity, host driver level, status pin and mute control
// Assumes: inputs synchronous to clk_sys; register port is the serial port's parallel side
// Notes:   all outputs except status_pin_o (tied low) are registered, one cycle behind their inputs, two behind a register write
module sdisc_top
  import sdisc_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic [5:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       direction_select,
  input  wire logic       reclock_bypass,
  input  wire logic       cdr_locked,
  input  wire logic [1:0] rate_code,
  input  wire logic       line_signal_found,
  input  wire logic       host_input_found,
  input  wire logic       adapt_done,
  input  wire logic       line_signal_loss,
  input  wire logic       host_signal_loss,
  input  wire logic       eye_width_low,
  input  wire logic       eye_height_low,
  input  wire logic [5:0] cable_boost_index,
  input  wire logic [3:0] host_level_strap,
  input  wire logic       host_output_select,
  output logic      [1:0] line_edge_rate,
  output logic            line_bidir_invert,
  output logic            line_aux_invert,
  output logic            host_output_invert,
  output logic            host_output_enable,
  output logic            host_output_loopback,
  output logic      [1:0] output_swing,
  output logic      [1:0] deemphasis_level,
  output logic            status_pin_o,
  output logic            status_pin_oe,
  output logic            mute_outputs
);

  // ************************************************
  // state
  // ************************************************
  typedef struct packed
  {
    logic [7:0] out_ctrl_reg;
    logic [7:0] host_drv_reg;
    logic [1:0] pin_cfg_reg;
    logic [6:0] int_mask_reg;
    logic [5:0] mute_thr_reg;
    logic [6:0] int_stat_reg;
    logic       line_loss_reg;
    logic       host_loss_reg;
    logic       lock_reg;
    logic [7:0] rdata_reg;
    logic [1:0] edge_reg;
    logic [1:0] swing_reg;
    logic [1:0] dem_reg;
    logic [2:0] inv_reg;
    logic       host_en_reg;
    logic       loopback_reg;
    logic       pin_low_reg;
    logic       mute_reg;
  } sdisc_state_t;

  sdisc_state_t s_reg;
  sdisc_state_t s_next;

  // strap level one-hot {l, r, f, h} to index; unknown mixes fall to the nominal level
  function automatic logic [1:0] sdisc_strap_code(input logic [3:0] lvl);
    logic [1:0] code;
    code = SDISC_LVL_F;
    if (lvl == 4'b0001)
      code = SDISC_LVL_H;
    else if (lvl == 4'b0100)
      code = SDISC_LVL_R;
    else if (lvl == 4'b1000)
      code = SDISC_LVL_L;
    return code;
  endfunction

  function automatic logic sdisc_hit(input logic [5:0] a, input logic [5:0] target, input logic strobe);
    return strobe && (a == target);
  endfunction

  logic       eq_mode;
  logic       rate_ok;
  logic       carrier_ok;
  logic       stat_read;
  logic [1:0] strap_code;
  logic [1:0] auto_edge;
  logic [6:0] int_events;

  // ************************************************
  // next state
  // ************************************************
  always_comb
  begin
    s_next     = s_reg;
    eq_mode    = !direction_select;
    rate_ok    = cdr_locked && (rate_code != SDISC_RATE_NONE);
    stat_read  = sdisc_hit(reg_addr, SDISC_INT_STAT_ADDR, reg_rd);
    strap_code = sdisc_strap_code(host_level_strap);

    // register writes
    if (sdisc_hit(reg_addr, SDISC_MUTE_THR_ADDR, reg_wr))
      s_next.mute_thr_reg = reg_wdata[5:0];
    else if (sdisc_hit(reg_addr, SDISC_OUT_CTRL_ADDR, reg_wr))
      s_next.out_ctrl_reg = {2'b00, reg_wdata[5:0]};
    else if (sdisc_hit(reg_addr, SDISC_HOST_DRV_ADDR, reg_wr))
      s_next.host_drv_reg = {2'b00, reg_wdata[5:0]};
    else if (sdisc_hit(reg_addr, SDISC_PIN_CFG_ADDR, reg_wr))
      s_next.pin_cfg_reg = reg_wdata[1:0];
    else if (sdisc_hit(reg_addr, SDISC_INT_MASK_ADDR, reg_wr))
      s_next.int_mask_reg = reg_wdata[6:0];

    // register reads, unmapped addresses read zero
    s_next.rdata_reg = 8'h00;
    if (sdisc_hit(reg_addr, SDISC_MUTE_THR_ADDR, reg_rd))
      s_next.rdata_reg = {2'b00, s_reg.mute_thr_reg};
    else if (sdisc_hit(reg_addr, SDISC_OUT_CTRL_ADDR, reg_rd))
      s_next.rdata_reg = s_reg.out_ctrl_reg;
    else if (sdisc_hit(reg_addr, SDISC_HOST_DRV_ADDR, reg_rd))
      s_next.rdata_reg = s_reg.host_drv_reg;
    else if (sdisc_hit(reg_addr, SDISC_PIN_CFG_ADDR, reg_rd))
      s_next.rdata_reg = {6'h00, s_reg.pin_cfg_reg};
    else if (sdisc_hit(reg_addr, SDISC_INT_MASK_ADDR, reg_rd))
      s_next.rdata_reg = {1'b0, s_reg.int_mask_reg};
    else if (stat_read)
      s_next.rdata_reg = {1'b0, s_reg.int_stat_reg};
    else if (sdisc_hit(reg_addr, SDISC_BOOST_ADDR, reg_rd))
      s_next.rdata_reg = {2'b00, cable_boost_index};

    // edge rate: automatic from recovered rate unless bypassed or forced
    case (rate_code)
      SDISC_RATE_3G: auto_edge = SDISC_EDGE_59PS;
      SDISC_RATE_HD: auto_edge = SDISC_EDGE_60PS;
      default:       auto_edge = SDISC_EDGE_550PS;
    endcase
    if (reclock_bypass || s_reg.out_ctrl_reg[SDISC_EDGE_OVR_BIT])
      s_next.edge_reg = s_reg.out_ctrl_reg[SDISC_EDGE_LSB +: 2];
    else
      s_next.edge_reg = auto_edge;

    s_next.inv_reg = s_reg.out_ctrl_reg[SDISC_INV_HOST_BIT:SDISC_INV_BIDIR_BIT];

    // host driver
    s_next.loopback_reg = direction_select;
    s_next.host_en_reg  = eq_mode || host_output_select;
    if (s_reg.host_drv_reg[SDISC_SWING_OVR_BIT])
      s_next.swing_reg = s_reg.host_drv_reg[SDISC_SWING_LSB +: 2];
    else if (eq_mode)
      s_next.swing_reg = strap_code;
    else
      s_next.swing_reg = SDISC_LVL_F;
    if (s_reg.host_drv_reg[SDISC_DEM_OVR_BIT])
      s_next.dem_reg = s_reg.host_drv_reg[SDISC_DEM_LSB +: 2];
    else if (eq_mode)
      s_next.dem_reg = strap_code;
    else
      s_next.dem_reg = SDISC_LVL_F;

    // interrupt sources, raw; the mask only gates the pin
    int_events                      = 7'h00;
    int_events[SDISC_INT_LINE_LOST] = eq_mode && line_signal_loss && !s_reg.line_loss_reg;
    int_events[SDISC_INT_LINE_BACK] = eq_mode && !line_signal_loss && s_reg.line_loss_reg;
    int_events[SDISC_INT_HOST_LOST] = !eq_mode && host_signal_loss && !s_reg.host_loss_reg;
    int_events[SDISC_INT_HOST_BACK] = !eq_mode && !host_signal_loss && s_reg.host_loss_reg;
    int_events[SDISC_INT_EYE_LOW]   = cdr_locked && (eye_width_low || eye_height_low);
    int_events[SDISC_INT_LOCK_GAIN] = cdr_locked && !s_reg.lock_reg;
    int_events[SDISC_INT_LOCK_LOSS] = !cdr_locked && s_reg.lock_reg;
    s_next.line_loss_reg = line_signal_loss;
    s_next.host_loss_reg = host_signal_loss;
    s_next.lock_reg      = cdr_locked;
    // a new event in the read cycle survives the clear
    s_next.int_stat_reg = (stat_read ? 7'h00 : s_reg.int_stat_reg) | int_events;

    // status pin
    carrier_ok = (eq_mode ? line_signal_found : host_input_found) && adapt_done;
    case (s_reg.pin_cfg_reg)
      SDISC_PIN_CARRIER: s_next.pin_low_reg = carrier_ok;
      SDISC_PIN_INTR:    s_next.pin_low_reg = |(s_next.int_stat_reg & s_reg.int_mask_reg);
      default:           s_next.pin_low_reg = rate_ok;
    endcase

    // threshold is in boost-index units, so it only means a length at one data rate
    s_next.mute_reg = eq_mode && (cable_boost_index > s_reg.mute_thr_reg);
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      s_reg              <= '0;
      s_reg.out_ctrl_reg <= SDISC_OUT_CTRL_RST;
      s_reg.host_drv_reg <= SDISC_HOST_DRV_RST;
      s_reg.pin_cfg_reg  <= SDISC_PIN_LOCK;
      s_reg.int_mask_reg <= SDISC_INT_MASK_RST;
      s_reg.mute_thr_reg <= SDISC_MUTE_THR_RST;
      s_reg.edge_reg     <= SDISC_EDGE_550PS;
      s_reg.swing_reg    <= SDISC_LVL_F;
      s_reg.dem_reg      <= SDISC_LVL_F;
    end
    else
      s_reg <= s_next;
  end

  // ************************************************
  // outputs
  // ************************************************
  assign reg_rdata            = s_reg.rdata_reg;
  assign line_edge_rate       = s_reg.edge_reg;
  assign line_bidir_invert    = s_reg.inv_reg[SDISC_INV_BIDIR_BIT];
  assign line_aux_invert      = s_reg.inv_reg[SDISC_INV_AUX_BIT];
  assign host_output_invert   = s_reg.inv_reg[SDISC_INV_HOST_BIT];
  assign host_output_enable   = s_reg.host_en_reg;
  assign host_output_loopback = s_reg.loopback_reg;
  assign output_swing         = s_reg.swing_reg;
  assign deemphasis_level     = s_reg.dem_reg;
  // open drain: only ever pulls low
  assign status_pin_o         = 1'b0;
  assign status_pin_oe        = s_reg.pin_low_reg;
  assign mute_outputs         = s_reg.mute_reg;

  // ************************************************
  // checks
  // ************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  edge_auto_sd_a: assert property ((!reclock_bypass && !s_reg.out_ctrl_reg[SDISC_EDGE_OVR_BIT]
    && rate_code == SDISC_RATE_SD) |=> line_edge_rate == SDISC_EDGE_550PS)
    else $error("edge rate not slow at sd rate");
  host_en_eq_a: assert property (!direction_select |=> host_output_enable)
    else $error("host output off in equalizer mode");
  swing_driver_a: assert property ((direction_select && !s_reg.host_drv_reg[SDISC_SWING_OVR_BIT])
    |=> output_swing == SDISC_LVL_F)
    else $error("driver mode swing not default");
  dem_override_a: assert property (s_reg.host_drv_reg[SDISC_DEM_OVR_BIT]
    |=> deemphasis_level == $past(s_reg.host_drv_reg[3:2]))
    else $error("de-emphasis override ignored");
  pin_lock_a: assert property ((s_reg.pin_cfg_reg == SDISC_PIN_LOCK && rate_ok) |=> status_pin_oe)
    else $error("status pin not low on lock");
  pin_intr_a: assert property ((s_reg.pin_cfg_reg == SDISC_PIN_INTR
    && (s_reg.int_stat_reg & s_reg.int_mask_reg) != 7'h00 && !stat_read) |=> status_pin_oe [*1])
    else $error("masked interrupt not on pin");
  int_sticky_a: assert property ((s_reg.int_stat_reg != 7'h00 && !stat_read)
    |=> (s_reg.int_stat_reg & $past(s_reg.int_stat_reg)) == $past(s_reg.int_stat_reg))
    else $error("interrupt flag lost before read");
  mute_a: assert property ((!direction_select && cable_boost_index > s_reg.mute_thr_reg) |=> mute_outputs)
    else $error("outputs not muted past threshold");
  boost_read_a: assert property (sdisc_hit(reg_addr, SDISC_BOOST_ADDR, reg_rd)
    |=> reg_rdata == {2'b00, $past(cable_boost_index)})
    else $error("boost index read mismatch");
  // event capture and clear-on-read as seen from the status register, then carrier pin, strap, edge, loopback and polarity
  stat_clear_a: assert property ((stat_read && int_events == 7'h00)
    |=> s_reg.int_stat_reg == 7'h00)
    else $error("interrupt status not cleared by read");
  line_back_a: assert property ((!direction_select && !line_signal_loss && s_reg.line_loss_reg)
    |=> s_reg.int_stat_reg[SDISC_INT_LINE_BACK])
    else $error("line signal return not recorded");
  host_back_a: assert property ((direction_select && !host_signal_loss && s_reg.host_loss_reg)
    |=> s_reg.int_stat_reg[SDISC_INT_HOST_BACK])
    else $error("host signal return not recorded");
  eye_low_a: assert property ((cdr_locked && eye_height_low)
    |=> s_reg.int_stat_reg[SDISC_INT_EYE_LOW])
    else $error("eye below threshold not recorded");
  pin_carrier_a: assert property ((s_reg.pin_cfg_reg == SDISC_PIN_CARRIER && !adapt_done)
    |=> !status_pin_oe)
    else $error("carrier pin low before adaptation done");
  swing_strap_a: assert property ((!direction_select && !s_reg.host_drv_reg[SDISC_SWING_OVR_BIT]
    && host_level_strap == 4'b1000) |=> output_swing == SDISC_LVL_L)
    else $error("strap level not applied to swing");
  edge_manual_a: assert property (reclock_bypass
    |=> line_edge_rate == $past(s_reg.out_ctrl_reg[5:4]))
    else $error("manual edge rate ignored in bypass");
  loopback_a: assert property (direction_select |=> host_output_loopback)
    else $error("no loopback in driver mode");
  inv_aux_a: assert property (s_reg.out_ctrl_reg[SDISC_INV_AUX_BIT] |=> line_aux_invert)
    else $error("aux polarity inversion ignored");

endmodule

//--- src/sdisc_pkg.sv
// Purpose: shared constants and types for the video I/O output, status and config block
// Assumes: 8-bit register port, 6-bit register addresses
// Notes:   swing and de-emphasis share one 2-bit index (0..3 = lightest..heaviest)
package sdisc_pkg;

  // ************************************************
  // register offsets
  // ************************************************
  localparam logic [5:0] SDISC_MUTE_THR_ADDR = 6'h03;
  localparam logic [5:0] SDISC_OUT_CTRL_ADDR = 6'h04;
  localparam logic [5:0] SDISC_HOST_DRV_ADDR = 6'h05;
  localparam logic [5:0] SDISC_PIN_CFG_ADDR  = 6'h06;
  localparam logic [5:0] SDISC_INT_MASK_ADDR = 6'h07;
  localparam logic [5:0] SDISC_INT_STAT_ADDR = 6'h08;
  localparam logic [5:0] SDISC_BOOST_ADDR    = 6'h25;

  // ************************************************
  // field positions
  // ************************************************
  localparam int SDISC_INV_BIDIR_BIT = 0;
  localparam int SDISC_INV_AUX_BIT   = 1;
  localparam int SDISC_INV_HOST_BIT  = 2;
  localparam int SDISC_EDGE_OVR_BIT  = 3;
  localparam int SDISC_EDGE_LSB      = 4;
  localparam int SDISC_SWING_LSB     = 0;
  localparam int SDISC_DEM_LSB       = 2;
  localparam int SDISC_SWING_OVR_BIT = 4;
  localparam int SDISC_DEM_OVR_BIT   = 5;

  localparam int SDISC_INT_LINE_LOST  = 0;
  localparam int SDISC_INT_LINE_BACK  = 1;
  localparam int SDISC_INT_HOST_LOST  = 2;
  localparam int SDISC_INT_HOST_BACK  = 3;
  localparam int SDISC_INT_EYE_LOW    = 4;
  localparam int SDISC_INT_LOCK_GAIN  = 5;
  localparam int SDISC_INT_LOCK_LOSS  = 6;
  localparam int SDISC_INT_COUNT      = 7;

  // ************************************************
  // reset values
  // ************************************************
  localparam logic [7:0] SDISC_OUT_CTRL_RST = 8'h00;
  localparam logic [7:0] SDISC_HOST_DRV_RST = 8'h05;
  localparam logic [6:0] SDISC_INT_MASK_RST = 7'h00;
  localparam logic [5:0] SDISC_MUTE_THR_RST = 6'h37;

  // ************************************************
  // encodings
  // ************************************************
  typedef enum logic [1:0]
  {
    SDISC_RATE_NONE = 2'b00,
    SDISC_RATE_3G   = 2'b01,
    SDISC_RATE_HD   = 2'b11,
    SDISC_RATE_SD   = 2'b10
  } sdisc_rate_t;

  typedef enum logic [1:0]
  {
    SDISC_EDGE_59PS  = 2'b00,
    SDISC_EDGE_60PS  = 2'b01,
    SDISC_EDGE_550PS = 2'b11
  } sdisc_edge_t;

  typedef enum logic [1:0]
  {
    SDISC_PIN_LOCK    = 2'b00,
    SDISC_PIN_CARRIER = 2'b01,
    SDISC_PIN_INTR    = 2'b11
  } sdisc_pinfn_t;

  // index 0: 400 mVp-p / 0 dB, 1: 570 / -0.4, 2: 660 / -2.1, 3: 830 / -4.4
  localparam logic [1:0] SDISC_LVL_H = 2'd0;
  localparam logic [1:0] SDISC_LVL_F = 2'd1;
  localparam logic [1:0] SDISC_LVL_R = 2'd2;
  localparam logic [1:0] SDISC_LVL_L = 2'd3;

endpackage

//--- verification/sdisc_host_model.sv
// Purpose: host controller model on the register port and the open-drain status pin
// Assumes: register strobes are one-cycle pulses, read data valid the cycle after
// Notes:   status pin has an external pull-up, so a released pin reads high
module sdisc_host_model
  import sdisc_pkg::*;
(
  input  wire logic       clk_sys,
  output logic      [5:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       status_pin_o,
  input  wire logic       status_pin_oe,
  output logic            status_pin_level
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    reg_addr  = 6'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // pull-up wins whenever the block lets go of the pin
  assign status_pin_level = status_pin_oe ? status_pin_o : 1'b1;

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;
  endtask

  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // reclocker bypassed: no automatic edge rate, so software sets it
  task automatic manual_edge(input sdisc_edge_t e);
    wr(SDISC_OUT_CTRL_ADDR, {2'b00, e, 1'b1, 3'b000});
  endtask

  // limit cable attached and SD video running before this is called
  task automatic calibrate();
    logic [7:0] v;
    rd(SDISC_BOOST_ADDR, v);
    wr(SDISC_MUTE_THR_ADDR, {2'b00, v[5:0]});
  endtask
endmodule

//--- verification/tb_sdi_output_status_config.sv
// Purpose: self-checking bench for the output, status and config block
// Assumes: host model drives the register port; level inputs driven here
// Notes:   signal loss and eye inputs are pulsed by the loss scenario only
module tb_sdi_output_status_config;
  import sdisc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clk_sys = 1'b0;
  logic       sys_rst = 1'b1;
  logic       direction_select = 1'b0;
  logic       reclock_bypass = 1'b0;
  logic       cdr_locked = 1'b0;
  logic [1:0] rate_code = 2'b00;
  logic       line_signal_found = 1'b0;
  logic       host_input_found = 1'b0;
  logic       adapt_done = 1'b0;
  logic [5:0] cable_boost_index = 6'h00;
  logic [3:0] host_level_strap = 4'h1;
  logic       host_output_select = 1'b0;
  logic       line_signal_loss = 1'b0;
  logic       host_signal_loss = 1'b0;
  logic       eye_width_low = 1'b0;
  logic       eye_height_low = 1'b0;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, d;
  logic       reg_wr, reg_rd, status_pin_o, status_pin_oe, status_pin_level;
  logic [1:0] line_edge_rate, output_swing, deemphasis_level;
  logic       line_bidir_invert, line_aux_invert, host_output_invert;
  logic       host_output_enable, host_output_loopback, mute_outputs;
  int         fail_count = 0;
  int         compares = 0;
  int         cycles = 0;

  always #2 clk_sys = ~clk_sys;

  sdisc_top u_sdisc_top (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .direction_select(direction_select),
    .reclock_bypass(reclock_bypass), .cdr_locked(cdr_locked), .rate_code(rate_code),
    .line_signal_found(line_signal_found), .host_input_found(host_input_found), .adapt_done(adapt_done),
    .line_signal_loss(line_signal_loss), .host_signal_loss(host_signal_loss), .eye_width_low(eye_width_low),
    .eye_height_low(eye_height_low),
    .cable_boost_index(cable_boost_index), .host_level_strap(host_level_strap),
    .host_output_select(host_output_select), .line_edge_rate(line_edge_rate),
    .line_bidir_invert(line_bidir_invert), .line_aux_invert(line_aux_invert),
    .host_output_invert(host_output_invert), .host_output_enable(host_output_enable),
    .host_output_loopback(host_output_loopback), .output_swing(output_swing),
    .deemphasis_level(deemphasis_level), .status_pin_o(status_pin_o), .status_pin_oe(status_pin_oe),
    .mute_outputs(mute_outputs));

  sdisc_host_model u_sdisc_host_model (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .status_pin_o(status_pin_o),
    .status_pin_oe(status_pin_oe), .status_pin_level(status_pin_level));

  task automatic results();
    if (fail_count == 0 && compares > 0)
    begin
      $display("Test passed");
    end
    else
    begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ************************************************
  // helpers
  // ************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // derived outputs trail a register write by two cycles
  task automatic settle();
    repeat (3) @(posedge clk_sys);
    #1;
  endtask

  // ************************************************
  // scenarios
  // ************************************************
  task automatic t_regs();
    u_sdisc_host_model.rd(SDISC_MUTE_THR_ADDR, d);
    chk(d, 8'h37);
    u_sdisc_host_model.rd(SDISC_HOST_DRV_ADDR, d);
    chk(d, 8'h05);
    chk({6'h00, line_edge_rate}, 8'h03);
    @(posedge clk_sys);
    cable_boost_index <= 6'd55;
    u_sdisc_host_model.wr(SDISC_BOOST_ADDR, 8'h00);
    u_sdisc_host_model.rd(SDISC_BOOST_ADDR, d);
    chk(d, 8'h37);
    u_sdisc_host_model.rd(6'h3f, d);
    chk(d, 8'h00);
  endtask

  task automatic t_edge();
    sdisc_rate_t rt [3] = '{SDISC_RATE_3G, SDISC_RATE_HD, SDISC_RATE_SD};
    sdisc_edge_t ex [3] = '{SDISC_EDGE_59PS, SDISC_EDGE_60PS, SDISC_EDGE_550PS};
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk_sys);
      rate_code <= rt[i];
      settle();
      chk({6'h00, line_edge_rate}, {6'h00, ex[i]});
    end
    @(posedge clk_sys);
    reclock_bypass <= 1'b1;
    u_sdisc_host_model.manual_edge(SDISC_EDGE_60PS);
    settle();
    chk({6'h00, line_edge_rate}, 8'h01);
    for (int i = 0; i < 8; i++)
    begin
      u_sdisc_host_model.wr(SDISC_OUT_CTRL_ADDR, 8'(i));
      settle();
      chk({5'h00, host_output_invert, line_aux_invert, line_bidir_invert}, 8'(i));
    end
    @(posedge clk_sys);
    reclock_bypass <= 1'b0;
  endtask

  task automatic t_host();
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk_sys);
      host_level_strap <= 4'h1 << i;
      settle();
      chk({4'h0, output_swing, deemphasis_level}, {4'h0, 2'(i), 2'(i)});
      chk({6'h00, host_output_enable, host_output_loopback}, 8'h02);
    end
    u_sdisc_host_model.wr(SDISC_HOST_DRV_ADDR, 8'h10);
    settle();
    chk({4'h0, output_swing, deemphasis_level}, 8'h03);
    @(posedge clk_sys);
    direction_select <= 1'b1;
    settle();
    chk({4'h0, output_swing, deemphasis_level}, 8'h01);
    chk({6'h00, host_output_enable, host_output_loopback}, 8'h01);
    u_sdisc_host_model.wr(SDISC_HOST_DRV_ADDR, 8'h05);
    @(posedge clk_sys);
    host_output_select <= 1'b1;
    settle();
    chk({6'h00, output_swing}, 8'h01);
    chk({7'h00, host_output_enable}, 8'h01);
    u_sdisc_host_model.wr(SDISC_HOST_DRV_ADDR, 8'h2c);
    settle();
    chk({4'h0, output_swing, deemphasis_level}, 8'h07);
  endtask

  task automatic t_status();
    @(posedge clk_sys);
    cdr_locked <= 1'b1;
    direction_select <= 1'b0;
    settle();
    chk({7'h00, status_pin_level}, 8'h00);
    u_sdisc_host_model.wr(SDISC_PIN_CFG_ADDR, 8'h01);
    @(posedge clk_sys);
    line_signal_found <= 1'b1;
    settle();
    chk({7'h00, status_pin_level}, 8'h01);
    @(posedge clk_sys);
    adapt_done <= 1'b1;
    settle();
    chk({7'h00, status_pin_level}, 8'h00);
    @(posedge clk_sys);
    direction_select <= 1'b1;
    settle();
    chk({7'h00, status_pin_level}, 8'h01);
    @(posedge clk_sys);
    host_input_found <= 1'b1;
    settle();
    chk({7'h00, status_pin_level}, 8'h00);
  endtask

  task automatic t_intr();
    u_sdisc_host_model.wr(SDISC_INT_MASK_ADDR, 8'h40);
    u_sdisc_host_model.wr(SDISC_PIN_CFG_ADDR, 8'h03);
    u_sdisc_host_model.rd(SDISC_INT_STAT_ADDR, d);
    settle();
    chk({7'h00, status_pin_level}, 8'h01);
    @(posedge clk_sys);
    cdr_locked <= 1'b0;
    settle();
    chk({7'h00, status_pin_level}, 8'h00);
    @(posedge clk_sys);
    cdr_locked <= 1'b1;
    settle();
    chk({7'h00, status_pin_level}, 8'h00);
    u_sdisc_host_model.rd(SDISC_INT_STAT_ADDR, d);
    chk(d & 8'h60, 8'h60);
    settle();
    chk({7'h00, status_pin_level}, 8'h01);
  endtask

  // starts in driver mode: line loss edges there must not be recorded
  task automatic t_loss();
    u_sdisc_host_model.wr(SDISC_INT_MASK_ADDR, 8'h1f);
    @(posedge clk_sys);
    line_signal_loss <= 1'b1;
    host_signal_loss <= 1'b1;
    settle();
    chk({7'h00, status_pin_level}, 8'h00);
    @(posedge clk_sys);
    host_signal_loss <= 1'b0;
    settle();
    @(posedge clk_sys);
    direction_select <= 1'b0;
    settle();
    @(posedge clk_sys);
    line_signal_loss <= 1'b0;
    settle();
    u_sdisc_host_model.rd(SDISC_INT_STAT_ADDR, d);
    chk(d, 8'h0e);
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clk_sys);
      {eye_height_low, eye_width_low} <= 2'(i + 1);
      settle();
      @(posedge clk_sys);
      {eye_height_low, eye_width_low} <= 2'b00;
      u_sdisc_host_model.rd(SDISC_INT_STAT_ADDR, d);
      chk(d, 8'h10);
    end
    settle();
    chk({7'h00, status_pin_level}, 8'h01);
  endtask

  task automatic t_mute();
    @(posedge clk_sys);
    direction_select <= 1'b0;
    cable_boost_index <= 6'd20;
    u_sdisc_host_model.calibrate();
    u_sdisc_host_model.rd(SDISC_MUTE_THR_ADDR, d);
    chk(d, 8'h14);
    settle();
    chk({7'h00, mute_outputs}, 8'h00);
    @(posedge clk_sys);
    cable_boost_index <= 6'd21;
    settle();
    chk({7'h00, mute_outputs}, 8'h01);
  endtask

  // hang guard: the scenarios need well under a thousand cycles
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      fail_count++;
      results();
    end
  end

  initial
  begin
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_regs();
    t_edge();
    t_host();
    t_status();
    t_intr();
    t_loss();
    t_mute();
    results();
  end
endmodule
